/* File: hdl/sfd_pkg.sv */
// Constants shared by the discoverable-table / reset / status front end.
// Assumes a mode-0 serial host and a 40 MHz device clock.
package sfd_pkg;

	// ------------------------------------------------------------------
	// Instruction codes
	// ------------------------------------------------------------------
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_VOL_WE = 8'h50;
	localparam logic [7:0] OP_WR_SR = 8'h01;
	localparam logic [7:0] OP_RD_SR = 8'h05;
	localparam logic [7:0] OP_RD_TBL = 8'h5A;
	localparam logic [7:0] OP_QUAD_EN = 8'h38;
	localparam logic [7:0] OP_QUAD_DIS = 8'hFF;

	// ------------------------------------------------------------------
	// Frame layout, counted in bits; dummy length counted in clocks
	// ------------------------------------------------------------------
	localparam logic [5:0] BYTE_BITS = 6'h08;
	localparam logic [5:0] ADDR_BITS = 6'h18;
	localparam logic [5:0] DUMMY_CLKS = 6'h08;
	localparam logic [5:0] STEP_SINGLE = 6'h01;
	localparam logic [5:0] STEP_QUAD = 6'h04;

	// ------------------------------------------------------------------
	// Discoverable table, sixteenth dword, bytes 68h..6Bh low byte first
	// ------------------------------------------------------------------
	localparam logic [7:0] TBL_DW16_BASE = 8'h68;
	localparam logic [7:0] TBL_DW16_LAST = 8'h6B;
	localparam logic [31:0] TBL_DW16 = 32'h80C030E8;
	localparam logic [7:0] TBL_BLANK = 8'hFF;

	// Output lane enables
	localparam logic [3:0] OE_SINGLE = 4'h2;
	localparam logic [3:0] OE_QUAD = 4'hF;

	typedef enum logic [2:0] {
		ST_CMD, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_DONE
	} sfd_state_t;

endpackage

/* File: hdl/sfd_pin_if.sv */
// Carries the synchronised serial pin events from the front end to the core.
// Assumes both ends run on the same device clock.
interface sfd_pin_if;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_act;
	logic cs_end;
	logic [3:0] io;

	modport front (
		output sclk_rise,
		output sclk_fall,
		output cs_act,
		output cs_end,
		output io
	);

	modport core (
		input sclk_rise,
		input sclk_fall,
		input cs_act,
		input cs_end,
		input io
	);
endinterface

/* File: hdl/sfd_sync.sv */
// Pin synchroniser and edge finder for the serial clock and chip select.
// Assumes the link clock runs well below a quarter of the device clock.
module sfd_sync import sfd_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Raw pins
	input wire logic spi_clk,
	input wire logic spi_cs_b,
	input wire logic [3:0] spi_io_i,
	// Events
	sfd_pin_if.front p
);

	logic [5:0] s1_q, s1_d;
	logic [5:0] s2_q, s2_d;
	logic [1:0] s3_q, s3_d;

	// ------------------------------------------------------------------
	// Two flops per pin, a third on clock and select for edges
	// ------------------------------------------------------------------
	always_comb begin
		s1_d = {spi_clk, spi_cs_b, spi_io_i};
		s2_d = s1_q;
		s3_d = s2_q[5:4];
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= 6'h10;
			s2_q <= 6'h10;
			s3_q <= 2'h1;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	assign p.sclk_rise = s2_q[5] & ~s3_q[1];
	assign p.sclk_fall = ~s2_q[5] & s3_q[1];
	assign p.cs_act = ~s2_q[4];
	assign p.cs_end = s2_q[4] & ~s3_q[0];
	assign p.io = s2_q[3:0];

endmodule

/* File: hdl/sfd_top.sv */
// Serial flash command core: table dword 16, soft reset, volatile status 1.
// Assumes a mode-0 host; nv_sr1 is static logic on the device clock.

// Summary of operation
// - Table bytes 68h..6Bh read E8,30,C0,80
// - Four-byte addressing can never be entered
// - Four-byte addressing has nothing to exit
// - Reset happens only after 66h then 99h
// - Reset pair taken at current wire width
// - Status 1 loads nonvolatile value at power-up
// - Instruction 50h enables volatile-only status write
// - Reset pair also returns to single wire
module sfd_top import sfd_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Serial pins
	input wire logic spi_clk,
	input wire logic spi_cs_b,
	input wire logic [3:0] spi_io_i,
	output logic [3:0] spi_io_o,
	output logic [3:0] spi_io_oe,
	// Status register 1
	input wire logic [7:0] nv_sr1,
	output logic [7:0] sr1,
	// Mode and reset state
	output logic quad_mode,
	output logic addr_4byte,
	output logic reset_armed,
	output logic soft_reset
);

	sfd_pin_if p ();

	sfd_sync u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.spi_clk(spi_clk),
		.spi_cs_b(spi_cs_b),
		.spi_io_i(spi_io_i),
		.p(p)
	);

	sfd_state_t st_q, st_d;
	logic [5:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] op_q, op_d;
	logic op_vld_q, op_vld_d;
	logic over_q, over_d;
	logic [23:0] addr_q, addr_d;
	logic [7:0] osh_q, osh_d;
	logic [3:0] ocnt_q, ocnt_d;
	logic [7:0] wr_q, wr_d;
	logic wr_ok_q, wr_ok_d;
	logic [3:0] io_o_q, io_o_d;
	logic [3:0] oe_q, oe_d;
	logic [7:0] sr1_q, sr1_d;
	logic load_q, load_d;
	logic quad_q, quad_d;
	logic addr4_q, addr4_d;
	logic rst_en_q, rst_en_d;
	logic vol_we_q, vol_we_d;
	logic sreset_q, sreset_d;

	logic [5:0] step;
	logic [5:0] cnt_nx;
	logic [7:0] byte_in;
	logic [7:0] fetch;
	logic [7:0] cur;
	logic [7:0] tidx;
	logic [5:0] dummy_bits;

	// ------------------------------------------------------------------
	// Lane width and readback byte
	// ------------------------------------------------------------------
	always_comb begin
		step = quad_q ? STEP_QUAD : STEP_SINGLE;
		cnt_nx = cnt_q + step;
		byte_in = quad_q ? {sh_q[3:0], p.io} : {sh_q[6:0], p.io[0]};
		dummy_bits = quad_q ? 6'(DUMMY_CLKS * STEP_QUAD) : DUMMY_CLKS;
		tidx = addr_q[7:0] - TBL_DW16_BASE;
		if (op_q == OP_RD_SR) begin
			fetch = sr1_q;
		end else if (addr_q[23:8] == 16'h0000 &&
			addr_q[7:0] >= TBL_DW16_BASE &&
			addr_q[7:0] <= TBL_DW16_LAST) begin
			fetch = TBL_DW16[{tidx[1:0], 3'h0} +: 8];
		end else begin
			fetch = TBL_BLANK;
		end
		cur = (ocnt_q == 4'h0) ? fetch : osh_q;
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		op_d = op_q;
		op_vld_d = op_vld_q;
		over_d = over_q;
		addr_d = addr_q;
		osh_d = osh_q;
		ocnt_d = ocnt_q;
		wr_d = wr_q;
		wr_ok_d = wr_ok_q;
		io_o_d = io_o_q;
		oe_d = oe_q;
		sr1_d = sr1_q;
		load_d = 1'b0;
		quad_d = quad_q;
		addr4_d = 1'b0;
		rst_en_d = rst_en_q;
		vol_we_d = vol_we_q;
		sreset_d = 1'b0;

		// Caught one edge after reset release, never inside the reset
		if (load_q) begin
			sr1_d = nv_sr1;
		end

		if (!p.cs_act) begin
			oe_d = 4'h0;
		end

		if (p.sclk_rise && p.cs_act) begin
			sh_d = byte_in;
			cnt_d = cnt_nx;
			case (st_q)
				ST_CMD: begin
					if (cnt_nx == BYTE_BITS) begin
						op_d = byte_in;
						op_vld_d = 1'b1;
						cnt_d = 6'h00;
						// Four-byte entry and exit codes fall to ST_DONE
						case (byte_in)
							OP_RD_TBL: st_d = ST_ADDR;
							OP_RD_SR: st_d = ST_RDATA;
							OP_WR_SR: st_d = ST_WDATA;
							default: st_d = ST_DONE;
						endcase
					end
				end
				ST_ADDR: begin
					addr_d = quad_q ? {addr_q[19:0], p.io} :
						{addr_q[22:0], p.io[0]};
					if (cnt_nx == ADDR_BITS) begin
						cnt_d = 6'h00;
						st_d = ST_DUMMY;
					end
				end
				ST_DUMMY: begin
					if (cnt_nx == dummy_bits) begin
						cnt_d = 6'h00;
						st_d = ST_RDATA;
					end
				end
				ST_WDATA: begin
					if (cnt_nx == BYTE_BITS) begin
						wr_d = byte_in;
						wr_ok_d = 1'b1;
						cnt_d = 6'h00;
						st_d = ST_DONE;
					end
				end
				ST_RDATA: begin
					cnt_d = 6'h00;
				end
				ST_DONE: begin
					// Extra clocks spoil a one-byte instruction
					over_d = 1'b1;
					cnt_d = 6'h00;
				end
				default: st_d = ST_DONE;
			endcase
		end

		// Data leaves on the falling edge so the host samples on the rise
		if (p.sclk_fall && p.cs_act && st_q == ST_RDATA) begin
			if (quad_q) begin
				io_o_d = cur[7:4];
				oe_d = OE_QUAD;
				osh_d = {cur[3:0], 4'h0};
			end else begin
				io_o_d = {2'b00, cur[7], 1'b0};
				oe_d = OE_SINGLE;
				osh_d = {cur[6:0], 1'b0};
			end
			ocnt_d = ocnt_q + step[3:0];
			if (ocnt_d == BYTE_BITS[3:0]) begin
				ocnt_d = 4'h0;
				addr_d = addr_q + 24'h000001;
			end
		end

		// Nothing acts before select rises; a cut frame can only clear the 66h and 50h enables
		if (p.cs_end) begin
			if (op_vld_q && !over_q && cnt_q == 6'h00) begin
				case (op_q)
					OP_RST_EN: rst_en_d = 1'b1;
					OP_RST: begin
						if (rst_en_q) begin
							quad_d = 1'b0;
							vol_we_d = 1'b0;
							sr1_d = nv_sr1;
							sreset_d = 1'b1;
						end
					end
					OP_VOL_WE: vol_we_d = 1'b1;
					OP_WR_SR: begin
						if (vol_we_q && wr_ok_q) begin
							sr1_d = wr_q;
						end
					end
					OP_QUAD_EN: quad_d = 1'b1;
					OP_QUAD_DIS: quad_d = 1'b0;
					default: quad_d = quad_q;
				endcase
			end
			if (op_vld_q && op_q != OP_RST_EN) begin
				rst_en_d = 1'b0;
			end
			if (op_vld_q && op_q != OP_VOL_WE) begin
				vol_we_d = 1'b0;
			end
			st_d = ST_CMD;
			cnt_d = 6'h00;
			ocnt_d = 4'h0;
			op_vld_d = 1'b0;
			over_d = 1'b0;
			wr_ok_d = 1'b0;
			oe_d = 4'h0;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= ST_CMD;
			cnt_q <= 6'h00;
			sh_q <= 8'h00;
			op_q <= 8'h00;
			op_vld_q <= 1'b0;
			over_q <= 1'b0;
			addr_q <= 24'h000000;
			osh_q <= 8'h00;
			ocnt_q <= 4'h0;
			wr_q <= 8'h00;
			wr_ok_q <= 1'b0;
			io_o_q <= 4'h0;
			oe_q <= 4'h0;
			sr1_q <= 8'h00;
			load_q <= 1'b1;
			quad_q <= 1'b0;
			addr4_q <= 1'b0;
			rst_en_q <= 1'b0;
			vol_we_q <= 1'b0;
			sreset_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			op_q <= op_d;
			op_vld_q <= op_vld_d;
			over_q <= over_d;
			addr_q <= addr_d;
			osh_q <= osh_d;
			ocnt_q <= ocnt_d;
			wr_q <= wr_d;
			wr_ok_q <= wr_ok_d;
			io_o_q <= io_o_d;
			oe_q <= oe_d;
			sr1_q <= sr1_d;
			load_q <= load_d;
			quad_q <= quad_d;
			addr4_q <= addr4_d;
			rst_en_q <= rst_en_d;
			vol_we_q <= vol_we_d;
			sreset_q <= sreset_d;
		end
	end

	assign spi_io_o = io_o_q;
	assign spi_io_oe = oe_q;
	assign sr1 = sr1_q;
	assign quad_mode = quad_q;
	assign addr_4byte = addr4_q;
	assign reset_armed = rst_en_q;
	assign soft_reset = sreset_q;

endmodule

/* File: sim/sfd_host_model.sv */
// Host-side partner: drives the serial pins in mode 0, MSB first.
// Assumes the device clock paces it, 8 clocks (200 ns) per serial clock cycle.
module sfd_host (
	// Clock
	input wire logic clk,
	// Resolved pin levels
	input wire logic [3:0] so,
	// Host-driven pins
	output logic sck,
	output logic cs_b,
	output logic [3:0] si
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sck = 1'b0;
		cs_b = 1'b1;
		si = 4'hA;
	end
	task automatic half();
		repeat (4) @(negedge clk);
	endtask
	task automatic start();
		cs_b = 1'b0;
		half();
	endtask
	// Data is taken just before the rise, when the device has settled it
	task automatic xbyte(input logic [7:0] b, input bit q,
		output logic [7:0] r);
		for (int i = 0; i < (q ? 2 : 8); i++) begin
			si = q ? b[7-4*i-:4] : {~si[3:1], b[7-i]};
			half();
			r = q ? {r[3:0], so} : {r[6:0], so[1]};
			sck = 1'b1;
			half();
			sck = 1'b0;
		end
	endtask
	// Never enters continuous read, so no exit is owed before a reset
	task automatic stop();
		half();
		cs_b = 1'b1;
		si = ~si;
		repeat (3) half();
	endtask
endmodule

/* File: sim/sfd_top_monitor.sv */
// Checker for sfd_top, bound to its ports.
// Assumes one clock domain and a host holding each pin level 4+ clocks.
module sfd_top_monitor import sfd_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Serial pins
	input wire logic spi_clk,
	input wire logic spi_cs_b,
	input wire logic [3:0] spi_io_i,
	input wire logic [3:0] spi_io_o,
	input wire logic [3:0] spi_io_oe,
	// Status and modes
	input wire logic [7:0] nv_sr1,
	input wire logic [7:0] sr1,
	input wire logic quad_mode,
	input wire logic addr_4byte,
	input wire logic reset_armed,
	input wire logic soft_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// Select has been high long enough to pass the synchroniser
	sequence s_cs_up;
		spi_cs_b && $past(spi_cs_b, 2);
	endsequence
	sequence s_rst_done;
		!quad_mode && !reset_armed && sr1 == nv_sr1;
	endsequence
	property p_no4b;
		addr_4byte == 1'b0;
	endproperty
	a_no4b: assert property (p_no4b)
		else $error("four-byte mode seen");
	property p_pulse;
		soft_reset |=> !soft_reset;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("reset pulse too long");
	property p_rst_state;
		soft_reset |-> s_rst_done ##1 !quad_mode;
	endproperty
	a_rst_state: assert property (p_rst_state)
		else $error("state after reset wrong");
	property p_armed;
		soft_reset |-> $past(reset_armed);
	endproperty
	a_armed: assert property (p_armed)
		else $error("reset without enable");
	property p_powerup;
		$rose(rst_b) |=> sr1 == nv_sr1;
	endproperty
	a_powerup: assert property (p_powerup)
		else $error("status not loaded at power-up");
	property p_quiet;
		$changed(reset_armed) || $changed(quad_mode)
			|| ($changed(sr1) && $past(rst_b, 2)) |-> s_cs_up;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("state changed inside a frame");
	property p_oe;
		spi_io_oe != 4'h0 |-> spi_io_oe == (quad_mode ? OE_QUAD : OE_SINGLE);
	endproperty
	a_oe: assert property (p_oe)
		else $error("wrong output lanes");
	property p_oe_off;
		spi_cs_b && $past(spi_cs_b, 4) |-> spi_io_oe == 4'h0;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("driving while deselected");
endmodule

/* File: sim/tb.sv */
// Self-checking bench for sfd_top against a reference model.
// Assumes sfd_host paces frames; checker is bound below the module.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sfd_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic sck, cs_b, soft_reset, quad_mode, addr_4byte, reset_armed;
	logic [3:0] si, so, oe, pin;
	logic [7:0] nv_sr1, sr1, r;
	logic [7:0] e_sr1 = 8'h00;
	logic [7:0] tbl [4] = '{8'hE8, 8'h30, 8'hC0, 8'h80};
	int errors = 0, cmp_count = 0, cyc = 0, pulses = 0, e_pulses = 0;
	bit e_arm, e_quad, e_vwe;
	always #12.5 clk = ~clk;
	// Device lanes win wherever it drives
	assign pin = (oe & so) | (~oe & si);
	sfd_top sfd_top_inst(.clk, .rst_b, .spi_clk(sck), .spi_cs_b(cs_b),
		.spi_io_i(pin), .spi_io_o(so), .spi_io_oe(oe), .nv_sr1, .sr1,
		.quad_mode, .addr_4byte, .reset_armed, .soft_reset);
	sfd_host sfd_host_inst(.clk, .so(pin), .sck, .cs_b, .si);
	always @(posedge clk) begin
		pulses <= pulses + (soft_reset === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			errors++;
		end
	endtask
	task automatic state();
		chk("reset_armed", 8'(e_arm), 8'(reset_armed));
		chk("quad_mode", 8'(e_quad), 8'(quad_mode));
		chk("addr_4byte", 8'h00, 8'(addr_4byte));
		chk("sr1", e_sr1, sr1);
		chk("resets", e_pulses[7:0], pulses[7:0]);
	endtask
	task automatic cmd(logic [7:0] op, logic [7:0] d, int nd);
		sfd_host_inst.start();
		sfd_host_inst.xbyte(op, e_quad, r);
		repeat (nd) sfd_host_inst.xbyte(d, e_quad, r);
		if (op == OP_RD_SR && nd > 0)
			chk("status_read", e_sr1, r);
		state();
		sfd_host_inst.stop();
		if (op == OP_RST && e_arm) begin
			e_quad = 1'b0;
			e_sr1 = nv_sr1;
			e_pulses++;
		end
		if (op == OP_WR_SR && e_vwe && nd == 1)
			e_sr1 = d;
		e_vwe = op == OP_VOL_WE;
		e_arm = op == OP_RST_EN;
		if (op == OP_QUAD_EN)
			e_quad = 1'b1;
		if (op == OP_QUAD_DIS)
			e_quad = 1'b0;
		state();
	endtask
	task automatic print_verdict();
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hF9C3));
		nv_sr1 = 8'($urandom);
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		e_sr1 = nv_sr1;
		state();
		cmd(OP_RST, 8'h00, 0);
		cmd(OP_RST_EN, 8'h00, 0);
		cmd(OP_RD_SR, 8'h00, 1);
		cmd(OP_RST, 8'h00, 0);
		cmd(OP_WR_SR, 8'($urandom), 1);
		for (int m = 0; m < 2; m++) begin
			if (m == 1) begin
				cmd(OP_QUAD_EN, 8'h00, 0);
				cmd(OP_QUAD_DIS, 8'h00, 0);
				cmd(OP_QUAD_EN, 8'h00, 0);
			end
			tread(8'h64 + 8'($urandom_range(4)), 8);
			cmd(8'hB7, 8'h00, 0);
			cmd(8'hE9, 8'h00, 0);
			cmd(OP_VOL_WE, 8'h00, 0);
			cmd(OP_WR_SR, 8'($urandom), 2);
			cmd(OP_VOL_WE, 8'h00, 0);
			cmd(OP_WR_SR, 8'($urandom), 1);
			cmd(OP_RD_SR, 8'h00, 1);
			cmd(OP_RST_EN, 8'h00, 0);
			cmd(OP_RST, 8'h00, 0);
		end
		// A second power-up must pick up the new nonvolatile value
		nv_sr1 = 8'($urandom);
		rst_b = 1'b0;
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		e_sr1 = nv_sr1;
		e_vwe = 1'b0;
		state();
		print_verdict();
	end
	// Reads n bytes from a; only the four dword bytes are defined
	task automatic tread(logic [7:0] a, int n);
		int x;
		logic [7:0] ev;
		sfd_host_inst.start();
		sfd_host_inst.xbyte(OP_RD_TBL, e_quad, r);
		sfd_host_inst.xbyte(8'h00, e_quad, r);
		sfd_host_inst.xbyte(8'h00, e_quad, r);
		sfd_host_inst.xbyte(a, e_quad, r);
		repeat (e_quad ? 4 : 1) sfd_host_inst.xbyte(8'hFF, e_quad, r);
		for (int i = 0; i < n; i++) begin
			sfd_host_inst.xbyte(8'hFF, e_quad, r);
			x = a + i;
			ev = (x >= 104 && x <= 107) ? tbl[x-104] : 8'hFF;
			chk("table", ev, r);
		end
		sfd_host_inst.stop();
		e_arm = 1'b0;
		e_vwe = 1'b0;
		state();
	endtask
endmodule
bind sfd_top sfd_top_monitor sfd_top_monitor_inst(.clk, .rst_b, .spi_clk,
	.spi_cs_b, .spi_io_i, .spi_io_o, .spi_io_oe, .nv_sr1, .sr1, .quad_mode,
	.addr_4byte, .reset_armed, .soft_reset);
